// ==== core/ces_rail_enable.sv ====
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module ces_rail_enable #(
    parameter int TICK_CYCLES = ces_pkg::CYCLES_PER_TICK
) (
    input  wire logic       sys_clk_i,
    input  wire logic       reset_i,
    input  wire logic [7:0] reg_addr_i,
    input  wire logic [7:0] reg_wdata_i,
    input  wire logic       reg_write_i,
    input  wire logic       reg_read_i,
    output logic [7:0]      reg_rdata_o,
    input  wire logic [5:0] control_input_i,
    input  wire logic [9:0] rail_power_good_i,
    output logic            rail_enable_o,
    output logic            voltage_increment_select_o
);
    // control_input_i[n] is control input n+1.
    // rail_power_good_i[7:0] pairs with mask bits 7..0; [9] shared
    // switch/LDO rail, [8] switch B1.

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0]          pg_mask;
        logic [7:0]          src_cfg;
        logic [7:0]          dly_cfg;
        logic [7:0]          rdata;
        logic [5:0]          ctl_s1;
        logic [5:0]          ctl_s2;
        logic [5:0]          ctl_s3;
        logic [9:0]          pg_s1;
        logic [9:0]          pg_s2;
        logic [9:0]          pg_s3;
        logic [5:0]          ctl_q;
        logic [9:0]          pg_q;
        ces_pkg::ces_state_e state;
        logic [5:0]          ticks;
        logic [27:0]         pre;
        logic                enable;
    } ces_regs_s;

    ces_regs_s r;
    ces_regs_s next_r;
    logic      src_level;
    logic      cond;
    logic      tick;
    logic [5:0] rise_ticks;
    logic [5:0] fall_ticks;
    logic [9:0] full_mask;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        full_mask = {r.src_cfg[1:0], r.pg_mask};
        case (r.src_cfg[ces_pkg::SOURCE_SELECT_LSB +: 3])
            ces_pkg::SRC_INPUT_ONE:   src_level = r.ctl_q[0];
            ces_pkg::SRC_INPUT_TWO:   src_level = r.ctl_q[1];
            ces_pkg::SRC_INPUT_FIVE:  src_level = r.ctl_q[4];
            ces_pkg::SRC_INPUT_FOUR:  src_level = r.ctl_q[3];
            ces_pkg::SRC_INPUT_THREE: src_level = r.ctl_q[2];
            ces_pkg::SRC_THREE_FOUR:  src_level = r.ctl_q[2] & r.ctl_q[3];
            ces_pkg::SRC_INPUT_SIX:   src_level = r.ctl_q[5];
            default:                  src_level = 1'b1;
        endcase
        // Masked flags count as good
        cond = src_level & (&(r.pg_q | full_mask));
        rise_ticks = ces_pkg::ces_delay_ticks(
            r.dly_cfg[ces_pkg::RISE_DELAY_LSB +: 3]);
        fall_ticks = ces_pkg::ces_delay_ticks(
            r.dly_cfg[ces_pkg::FALL_DELAY_LSB +: 3]);
        // Base tick pulse; every delay is a whole count of these
        tick = (r.pre == 28'(TICK_CYCLES - 1));
    end

    always_comb begin
        next_r = r;
        // The first stage may settle late, so only the second reads it
        next_r.ctl_s1 = control_input_i;
        next_r.ctl_s2 = r.ctl_s1;
        next_r.ctl_s3 = r.ctl_s2;
        next_r.pg_s1  = rail_power_good_i;
        next_r.pg_s2  = r.pg_s1;
        next_r.pg_s3  = r.pg_s2;
        // A bit changes only once the last two stages agree
        for (int i = 0; i < 6; i++) begin
            if (r.ctl_s2[i] == r.ctl_s3[i]) begin
                next_r.ctl_q[i] = r.ctl_s3[i];
            end
        end
        for (int i = 0; i < 10; i++) begin
            if (r.pg_s2[i] == r.pg_s3[i]) begin
                next_r.pg_q[i] = r.pg_s3[i];
            end
        end

        // Read data stand for one cycle, zero otherwise
        next_r.rdata = 8'h00;
        if (reg_write_i) begin
            case (reg_addr_i)
                ces_pkg::ADDR_POWER_GOOD_MASK: next_r.pg_mask = reg_wdata_i;
                ces_pkg::ADDR_SOURCE_CFG:      next_r.src_cfg = reg_wdata_i;
                ces_pkg::ADDR_DELAY_CFG:       next_r.dly_cfg = reg_wdata_i;
                default: ;
            endcase
        end
        if (reg_read_i) begin
            case (reg_addr_i)
                ces_pkg::ADDR_POWER_GOOD_MASK: next_r.rdata = r.pg_mask;
                ces_pkg::ADDR_SOURCE_CFG:      next_r.rdata = r.src_cfg;
                ces_pkg::ADDR_DELAY_CFG:       next_r.rdata = r.dly_cfg;
                default:                       next_r.rdata = 8'h00;
            endcase
        end

        next_r.pre = tick ? 28'h0000000 : r.pre + 28'h0000001;
        // Timers restart on any change, so a glitch never shortens a delay
        case (r.state)
            ces_pkg::CES_OFF: begin
                if (cond) begin
                    if (rise_ticks == 6'h00) begin
                        next_r.state  = ces_pkg::CES_ON;
                        next_r.enable = 1'b1;
                    end else begin
                        next_r.state = ces_pkg::CES_RISING;
                        next_r.ticks = 6'h00;
                        next_r.pre   = 28'h0000000;
                    end
                end
            end
            // A code changed mid-delay applies from the next tick
            ces_pkg::CES_RISING: begin
                if (!cond) begin
                    next_r.state = ces_pkg::CES_OFF;
                end else if (tick) begin
                    next_r.ticks = r.ticks + 6'h01;
                    if (r.ticks + 6'h01 >= rise_ticks) begin
                        next_r.state  = ces_pkg::CES_ON;
                        next_r.enable = 1'b1;
                    end
                end
            end
            ces_pkg::CES_ON: begin
                if (!cond) begin
                    if (fall_ticks == 6'h00) begin
                        next_r.state  = ces_pkg::CES_OFF;
                        next_r.enable = 1'b0;
                    end else begin
                        next_r.state = ces_pkg::CES_FALLING;
                        next_r.ticks = 6'h00;
                        next_r.pre   = 28'h0000000;
                    end
                end
            end
            ces_pkg::CES_FALLING: begin
                if (cond) begin
                    next_r.state = ces_pkg::CES_ON;
                end else if (tick) begin
                    next_r.ticks = r.ticks + 6'h01;
                    if (r.ticks + 6'h01 >= fall_ticks) begin
                        next_r.state  = ces_pkg::CES_OFF;
                        next_r.enable = 1'b0;
                    end
                end
            end
            default: begin
                next_r.state  = ces_pkg::CES_OFF;
                next_r.enable = 1'b0;
            end
        endcase
    end

    // Clear everything, then load the register reset values
    always_ff @(posedge sys_clk_i) begin
        if (reset_i) begin
            r         <= '0;
            r.pg_mask <= ces_pkg::RESET_POWER_GOOD_MASK;
            r.src_cfg <= ces_pkg::RESET_SOURCE_CFG;
            r.dly_cfg <= ces_pkg::RESET_DELAY_CFG;
            r.state   <= ces_pkg::CES_OFF;
        end else begin
            r <= next_r;
        end
    end

    assign reg_rdata_o   = r.rdata;
    assign rail_enable_o = r.enable;
    // Meant to be set once at configuration, not while the rail runs
    assign voltage_increment_select_o =
        r.src_cfg[ces_pkg::STEP_SELECT_BIT];

    ////////////////////////////////////////////////////////////////////////
    a_enable_needs_cond: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        $rose(rail_enable_o) |-> $past(cond))
        else $error("rail enabled without enable condition");

    a_mask_clear_blocks: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (!r.pg_mask[0] && !r.pg_q[0]) |-> !cond)
        else $error("unmasked bad flag did not block enable");

    a_mask_set_ignores: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.pg_mask == 8'hFF && r.src_cfg[1:0] == 2'h3
         && r.src_cfg[4:2] == 3'h7) |-> cond)
        else $error("masked flags still affect enable");

    a_shared_mask: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (!r.src_cfg[1] && !r.pg_q[9]) |-> !cond)
        else $error("shared rail flag ignored while included");

    a_step_select: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (reg_write_i && reg_addr_i == ces_pkg::ADDR_SOURCE_CFG)
        |=> voltage_increment_select_o == $past(reg_wdata_i[5]))
        else $error("step select not taken from write");

    a_pair_source: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.src_cfg[4:2] == 3'h5 && !r.ctl_q[3]) |-> !cond)
        else $error("paired source enabled with input four low");

    a_always_on: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.src_cfg[4:2] == 3'h7) |-> src_level)
        else $error("constant source not high");

    a_no_rise_delay: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_OFF && cond && rise_ticks == 6'h00)
        |=> rail_enable_o)
        else $error("zero rise delay not immediate");

    a_no_fall_delay: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_ON && !cond && fall_ticks == 6'h00)
        |=> !rail_enable_o)
        else $error("zero fall delay not immediate");

    a_delay_decode: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.dly_cfg[2:0] == 3'h5) |-> rise_ticks == 6'h0C)
        else $error("24 ms code mis-decoded");

    a_fall_restart: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_FALLING && cond)
        |=> (r.state == ces_pkg::CES_ON && rail_enable_o))
        else $error("falling timer not cancelled");

    // Each delay state keeps the enable at the level it started from
    a_rise_held_low: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_RISING) |-> !rail_enable_o)
        else $error("enable high during rise delay");

    a_fall_held_high: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_FALLING) |-> rail_enable_o)
        else $error("enable low during fall delay");

    a_rise_not_early: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_OFF && cond && rise_ticks != 6'h00)
        |=> !rail_enable_o)
        else $error("enable rose before rise delay");

    a_fall_not_early: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_ON && !cond && fall_ticks != 6'h00)
        |=> rail_enable_o)
        else $error("enable fell before fall delay");

    a_rise_abort: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_RISING && !cond)
        |=> (r.state == ces_pkg::CES_OFF && !rail_enable_o))
        else $error("rising timer not cancelled");

    a_on_holds: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_ON && cond) |=> rail_enable_o)
        else $error("enable dropped with condition true");

    a_off_holds: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.state == ces_pkg::CES_OFF && !cond) |=> !rail_enable_o)
        else $error("enable rose with condition false");

    a_disable_needs_low: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        $fell(rail_enable_o) |-> !$past(cond))
        else $error("rail disabled with enable condition true");

    a_fall_decode: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.dly_cfg[5:3] == 3'h7) |-> fall_ticks == 6'h20)
        else $error("64 ms fall code mis-decoded");

    a_rise_decode_two: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.dly_cfg[2:0] == 3'h1) |-> rise_ticks == 6'h01)
        else $error("2 ms rise code mis-decoded");

    // Source decode and mask gating
    a_input_two: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.src_cfg[4:2] == 3'h1) |-> src_level == r.ctl_q[1])
        else $error("source code 1 not input two");

    a_source_five: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.src_cfg[4:2] == 3'h2) |-> src_level == r.ctl_q[4])
        else $error("source code 2 not input five");

    a_source_three: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.src_cfg[4:2] == 3'h4) |-> src_level == r.ctl_q[2])
        else $error("source code 4 not input three");

    a_input_six: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.src_cfg[4:2] == 3'h6) |-> src_level == r.ctl_q[5])
        else $error("source code 6 not input six");

    a_pair_needs_three: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (r.src_cfg[4:2] == 3'h5 && !r.ctl_q[2]) |-> !cond)
        else $error("paired source enabled with input three low");

    a_mask_top_bit: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (!r.pg_mask[7] && !r.pg_q[7]) |-> !cond)
        else $error("unmasked bad top flag did not block enable");

    a_switch_b_one: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (!r.src_cfg[0] && !r.pg_q[8]) |-> !cond)
        else $error("switch B1 flag ignored while included");

    // Register side
    a_read_delay_reg: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        (reg_read_i && reg_addr_i == ces_pkg::ADDR_DELAY_CFG)
        |=> reg_rdata_o == $past(r.dly_cfg))
        else $error("delay register read back wrong");

    a_step_holds: assert property (@(posedge sys_clk_i)
        disable iff (reset_i)
        !(reg_write_i && reg_addr_i == ces_pkg::ADDR_SOURCE_CFG)
        |=> $stable(voltage_increment_select_o))
        else $error("step select changed without a write");
endmodule : ces_rail_enable

// ==== core/ces_pkg.sv ====
// Operation
// - Mask register bits 7..0 gate eight rail power-good flags; 0 includes.
// - A mask bit of 1 removes that rail's power-good from the enable.
// - Source register bit 1 masks shared switch/LDO, bit 0 masks switch B1.
// - Source register bit 5 picks 10 mV (0) or 25 mV (1) steps.
// - Source bits 4:2 pick control input 1,2,5,4,3, 3 and 4, or 6.
// - Source code 111 feeds a constant one; no input needed.
// - Delay register bits 5:3 set the delay after the enable falls.
// - Delay register bits 2:0 set the delay after the enable rises.
// - Delay codes map to 0, 2, 4, 8, 16, 24, 32, 64 ms.
package ces_pkg;
    localparam logic [7:0] ADDR_POWER_GOOD_MASK = 8'h0A;
    localparam logic [7:0] ADDR_SOURCE_CFG      = 8'h0B;
    localparam logic [7:0] ADDR_DELAY_CFG       = 8'h0C;
    localparam logic [7:0] RESET_POWER_GOOD_MASK = 8'h00;
    localparam logic [7:0] RESET_SOURCE_CFG      = 8'hC0;
    localparam logic [7:0] RESET_DELAY_CFG       = 8'h00;
    localparam int STEP_SELECT_BIT   = 5;
    localparam int SOURCE_SELECT_LSB = 2;
    localparam int FALL_DELAY_LSB    = 3;
    localparam int RISE_DELAY_LSB    = 0;
    localparam int CLOCK_HZ          = 200_000_000;
    localparam int MS_PER_TICK       = 2;
    // Base tick of 2 ms; every delay is a whole number of ticks
    localparam int CYCLES_PER_TICK   = CLOCK_HZ / 1000 * MS_PER_TICK;
    localparam logic [2:0] SRC_INPUT_ONE   = 3'h0;
    localparam logic [2:0] SRC_INPUT_TWO   = 3'h1;
    localparam logic [2:0] SRC_INPUT_FIVE  = 3'h2;
    localparam logic [2:0] SRC_INPUT_FOUR  = 3'h3;
    localparam logic [2:0] SRC_INPUT_THREE = 3'h4;
    localparam logic [2:0] SRC_THREE_FOUR  = 3'h5;
    localparam logic [2:0] SRC_INPUT_SIX   = 3'h6;
    localparam logic [2:0] SRC_ALWAYS_ON   = 3'h7;
    typedef enum logic [3:0] {
        CES_OFF     = 4'h1,
        CES_RISING  = 4'h2,
        CES_ON      = 4'h4,
        CES_FALLING = 4'h8
    } ces_state_e;
    // Delay in 2 ms ticks per code
    function automatic logic [5:0] ces_delay_ticks(input logic [2:0] code);
        case (code)
            3'h0:    ces_delay_ticks = 6'h00;
            3'h1:    ces_delay_ticks = 6'h01;
            3'h2:    ces_delay_ticks = 6'h02;
            3'h3:    ces_delay_ticks = 6'h04;
            3'h4:    ces_delay_ticks = 6'h08;
            3'h5:    ces_delay_ticks = 6'h0C;
            3'h6:    ces_delay_ticks = 6'h10;
            default: ces_delay_ticks = 6'h20;
        endcase
    endfunction : ces_delay_ticks
endpackage : ces_pkg

// ==== testbench/ces_system_pins.sv ====
`timescale 1ns/10ps
module ces_system_pins (
    input  wire logic       sys_clk_i,
    input  wire logic       slow_i,
    input  wire logic [5:0] ctl_req_i,
    input  wire logic [9:0] good_req_i,
    output logic [5:0]      control_input_o,
    output logic [9:0]      rail_power_good_o
);
    logic [15:0] lag;
    // Slow mode adds a cycle, like a pin behind a longer board path
    always @(posedge sys_clk_i) begin
        lag <= {good_req_i, ctl_req_i};
        {rail_power_good_o, control_input_o} <=
            slow_i ? lag : {good_req_i, ctl_req_i};
    end
endmodule : ces_system_pins

// ==== testbench/ces_rail_enable_test.sv ====
`timescale 1ns/10ps
module ces_rail_enable_test;
    localparam int TK = 4;
    logic       sys_clk_i = 1'b0;
    logic       reset_i   = 1'b1;
    logic [7:0] addr      = 8'h00;
    logic [7:0] wdata     = 8'h00;
    logic       wr        = 1'b0;
    logic       rd        = 1'b0;
    logic       slow      = 1'b0;
    logic [5:0] ctl_req   = 6'h00;
    logic [9:0] pg_req    = 10'h3FF;
    logic [7:0] rdata;
    logic [5:0] ctl;
    logic [9:0] pg;
    logic       en;
    logic       step;
    logic [7:0] got;
    int n_errors = 0;
    int compares = 0;
    int cycles   = 0;
    int d;
    int ms[8] = '{0, 2, 4, 8, 16, 24, 32, 64};
    logic [5:0] pm[7] = '{6'h01, 6'h02, 6'h10, 6'h08, 6'h04, 6'h0C, 6'h20};
    always #2.5 sys_clk_i = ~sys_clk_i;
    ces_system_pins pins (.sys_clk_i(sys_clk_i), .slow_i(slow),
        .ctl_req_i(ctl_req), .good_req_i(pg_req),
        .control_input_o(ctl), .rail_power_good_o(pg));
    ces_rail_enable #(.TICK_CYCLES(TK)) dut (.sys_clk_i(sys_clk_i),
        .reset_i(reset_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_write_i(wr), .reg_read_i(rd), .reg_rdata_o(rdata),
        .control_input_i(ctl), .rail_power_good_i(pg),
        .rail_enable_o(en), .voltage_increment_select_o(step));
    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("errors %0d compares %0d", n_errors, compares);
        if (n_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : end_of_test
    task automatic check_reg(input logic [7:0] g, input logic [7:0] e);
        compares++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, g, e);
        end
    endtask : check_reg
    task automatic check_lat(input int n, input int lo, input int hi);
        compares++;
        if (n < lo || n > hi) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h..%h", $time, n, lo, hi);
        end
    endtask : check_lat
    task automatic reg_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_i);
        addr  <= a;
        wdata <= v;
        wr    <= 1'b1;
        @(posedge sys_clk_i);
        wr    <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk_i);
        addr <= a;
        rd   <= 1'b1;
        @(posedge sys_clk_i);
        rd   <= 1'b0;
        @(posedge sys_clk_i);
        v = rdata;
    endtask : reg_read
    // Cycles until the enable reaches a level; 400 means it never did
    task automatic wait_en(input logic lvl, input int lo, input int hi);
        int n;
        n = 0;
        while (en !== lvl && n < 400) begin
            @(posedge sys_clk_i);
            n++;
        end
        check_lat(n, lo, hi);
    endtask : wait_en
    ////////////////////////////////////////////////////////////////////
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    initial begin
        repeat (16) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        reg_read(8'h0A, got); check_reg(got, 8'h00);
        reg_read(8'h0B, got); check_reg(got, 8'hC0);
        reg_read(8'h0C, got); check_reg(got, 8'h00);
        reg_write(8'h0D, 8'hFF);
        reg_read(8'h0D, got); check_reg(got, 8'h00);
        check_reg({7'h00, en}, 8'h00);
        reg_write(8'h0B, 8'h3C);
        #1 check_reg({7'h00, step}, 8'h01);
        reg_write(8'h0B, 8'h1C);
        #1 check_reg({7'h00, step}, 8'h00);
        wait_en(1'b1, 0, 12);
        for (int s = 0; s < 7; s++) begin
            reg_write(8'h0B, 8'(s << 2));
            @(posedge sys_clk_i);
            ctl_req <= (s == 5) ? 6'h3B : ~pm[s];
            wait_en(1'b0, 0, 12);
            wait_en(1'b1, 400, 400);
            ctl_req <= pm[s];
            wait_en(1'b1, 3, 10);
            @(posedge sys_clk_i);
            ctl_req <= 6'h00;
            wait_en(1'b0, 3, 10);
        end
        for (int i = 0; i < 10; i++) begin
            @(posedge sys_clk_i);
            pg_req <= ~(10'h001 << i);
            repeat (6) @(posedge sys_clk_i);
            reg_write(8'h0A, 8'h00);
            reg_write(8'h0B, 8'h1C);
            wait_en(1'b0, 0, 14);
            wait_en(1'b1, 400, 400);
            if (i < 8) reg_write(8'h0A, 8'(1 << i));
            else reg_write(8'h0B, 8'h1C | 8'(1 << (i - 8)));
            wait_en(1'b1, 0, 12);
        end
        reg_write(8'h0A, 8'hFF);
        reg_write(8'h0B, 8'h1F);
        @(posedge sys_clk_i);
        pg_req <= 10'h000;
        wait_en(1'b0, 400, 400);
        @(posedge sys_clk_i);
        pg_req <= 10'h3FF;
        reg_write(8'h0B, 8'h00);
        wait_en(1'b0, 0, 12);
        for (int k = 0; k < 8; k++) begin
            d = ms[k] / ces_pkg::MS_PER_TICK * TK;
            reg_write(8'h0C, 8'hC0 | 8'(k << 3) | 8'(k));
            reg_read(8'h0C, got); check_reg(got, 8'hC0 | 8'(k * 9));
            slow <= k[0];
            ctl_req <= 6'h01;
            wait_en(1'b1, d + 3, d + 11);
            @(posedge sys_clk_i);
            ctl_req <= 6'h00;
            wait_en(1'b0, d + 3, d + 11);
        end
        // Rise delay 64 ms aborted part way; then fall delay aborted
        reg_write(8'h0C, 8'h07);
        ctl_req <= 6'h01;
        repeat (40) @(posedge sys_clk_i);
        ctl_req <= 6'h00;
        wait_en(1'b1, 400, 400);
        reg_write(8'h0C, 8'h38);
        ctl_req <= 6'h01;
        wait_en(1'b1, 3, 11);
        @(posedge sys_clk_i);
        ctl_req <= 6'h00;
        repeat (40) @(posedge sys_clk_i);
        ctl_req <= 6'h01;
        wait_en(1'b0, 400, 400);
        reset_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        reset_i <= 1'b0;
        #1 check_reg({7'h00, en}, 8'h00);
        reg_read(8'h0A, got); check_reg(got, 8'h00);
        reg_read(8'h0B, got); check_reg(got, 8'hC0);
        end_of_test();
    end
endmodule : ces_rail_enable_test
